// [hdl/hfpc_map.svh]
// Constant map of the half-bridge PWM freewheel controller
`ifndef HFPC_MAP_SVH
`define HFPC_MAP_SVH

// Structure
`define HFPC_NUM_HB 4
`define HFPC_CW 10
`define HFPC_MODE_W 2
`define HFPC_CODE_W 6
`define HFPC_CODE_N 64
`define HFPC_CUR_W 11
// Decoded current LSB in microamperes
`define HFPC_CUR_LSB_UA 50

// Half-bridge mode codes
`define HFPC_MODE_OFF 2'h0
`define HFPC_MODE_HS 2'h1
`define HFPC_MODE_LS 2'h2

// Switching time status word layout
`define HFPC_STAT_W 32
`define HFPC_TF_W 8
`define HFPC_TDON_LSB 0
`define HFPC_TDOFF_LSB 8
`define HFPC_TRISE_LSB 16
`define HFPC_TFALL_LSB 24

// Pump undervoltage blank time in cycles
`define HFPC_CP_BLANK_CYC 1024

`endif

// [hdl/hfpc_pkg.sv]
// Types of the half-bridge PWM freewheel controller
package hfpc_pkg;

  typedef enum logic [3:0] {
    SEQ_FW = 4'h1,
    SEQ_DT_ON = 4'h2,
    SEQ_ACT = 4'h4,
    SEQ_DT_OFF = 4'h8
  } hfpc_seq_type;

  typedef enum logic [4:0] {
    M_IDLE = 5'h01,
    M_DON = 5'h02,
    M_RISE = 5'h04,
    M_DOFF = 5'h08,
    M_FALL = 5'h10
  } hfpc_meas_type;

endpackage

// [hdl/hfpc_cur_decode.sv]
// Discharge current code to nominal current decoder
`timescale 1ns/1ps
`include "hfpc_map.svh"

module hfpc_cur_decode
  import hfpc_pkg::*;
(
  input wire logic clk_sys,
  input wire logic srst,
  input wire logic ce,
  input wire logic [`HFPC_CODE_W-1:0] code,
  output logic [`HFPC_CUR_W-1:0] current
);

  // Nominal current per code, code 63 first, strictly rising
  localparam logic [`HFPC_CODE_N*`HFPC_CUR_W-1:0] CUR_TBL = {
    11'h7D0, 11'h79C, 11'h768, 11'h734, 11'h700, 11'h6CE, 11'h69C, 11'h66A,
    11'h638, 11'h608, 11'h5D8, 11'h5A8, 11'h578, 11'h54A, 11'h51C, 11'h4F0,
    11'h4C6, 11'h49C, 11'h474, 11'h44C, 11'h424, 11'h3FC, 11'h3D4, 11'h3AC,
    11'h386, 11'h360, 11'h33A, 11'h314, 11'h2F0, 11'h2CC, 11'h2A8, 11'h284,
    11'h260, 11'h23C, 11'h21A, 11'h1F8, 11'h1D6, 11'h1B6, 11'h196, 11'h178,
    11'h15C, 11'h142, 11'h128, 11'h10E, 11'h0F6, 11'h0E0, 11'h0CC, 11'h0B8,
    11'h0A4, 11'h092, 11'h082, 11'h072, 11'h064, 11'h056, 11'h04A, 11'h03E,
    11'h032, 11'h02A, 11'h022, 11'h01B, 11'h016, 11'h011, 11'h00D, 11'h00A
  };

  function automatic logic [`HFPC_CUR_W-1:0] lookup(input logic [`HFPC_CODE_W-1:0] c);
    lookup = CUR_TBL[c*`HFPC_CUR_W +: `HFPC_CUR_W];
  endfunction

  always_ff @(posedge clk_sys) begin
    if (srst) begin
      current <= '0;
    end else if (ce) begin
      current <= lookup(code);
    end
  end

endmodule

// [hdl/hfpc_edge_delay.sv]
// Two-edge delay line for the shifted PWM MOSFET command
`timescale 1ns/1ps
`include "hfpc_map.svh"

module hfpc_edge_delay
  import hfpc_pkg::*;
#(
  parameter int CW = `HFPC_CW
) (
  input wire logic clk_sys,
  input wire logic srst,
  input wire logic ce,
  input wire logic din,
  input wire logic [CW-1:0] dly,
  output logic dout
);

  // Two slots cover a pulse shorter than the delay; a third edge is dropped
  logic in_q;
  logic v0_q;
  logic v1_q;
  logic t0_q;
  logic t1_q;
  logic [CW-1:0] c0_q;
  logic [CW-1:0] c1_q;
  logic edge_w;
  logic fire;

  assign edge_w = din ^ in_q;
  assign fire = v0_q && (c0_q <= CW'(1));

  always_ff @(posedge clk_sys) begin
    if (srst) begin
      in_q <= 1'b0;
      dout <= 1'b0;
      v0_q <= 1'b0;
      v1_q <= 1'b0;
      t0_q <= 1'b0;
      t1_q <= 1'b0;
      c0_q <= '0;
      c1_q <= '0;
    end else if (ce) begin
      in_q <= din;
      if (fire) begin
        dout <= t0_q;
        if (v1_q) begin
          v0_q <= 1'b1;
          t0_q <= t1_q;
          c0_q <= (c1_q != '0) ? c1_q - 1'b1 : '0;
          v1_q <= edge_w;
          t1_q <= din;
          c1_q <= dly;
        end else begin
          v0_q <= edge_w;
          t0_q <= din;
          c0_q <= dly;
        end
      end else begin
        if (v0_q && c0_q != '0) begin
          c0_q <= c0_q - 1'b1;
        end
        if (v1_q && c1_q != '0) begin
          c1_q <= c1_q - 1'b1;
        end
        if (edge_w && !v0_q) begin
          v0_q <= 1'b1;
          t0_q <= din;
          c0_q <= dly;
        end else if (edge_w && !v1_q) begin
          v1_q <= 1'b1;
          t1_q <= din;
          c1_q <= dly;
        end
      end
    end
  end

endmodule

// [hdl/hfpc_top.sv]
// Half-bridge PWM control with active freewheeling and passive discharge
`timescale 1ns/1ps
`include "hfpc_map.svh"

module hfpc_top
  import hfpc_pkg::*;
#(
  parameter int CW = `HFPC_CW,
  parameter int CP_BLANK_CYC = `HFPC_CP_BLANK_CYC
) (
  input wire logic clk_sys,
  input wire logic srst,
  input wire logic ce,
  input wire logic [`HFPC_NUM_HB-1:0] pwm_in,
  input wire logic [`HFPC_NUM_HB-1:0] active_freewheel_enable,
  input wire logic generator_detect_enable,
  input wire logic [`HFPC_NUM_HB-1:0][`HFPC_MODE_W-1:0] halfbridge_mode_select,
  input wire logic [`HFPC_NUM_HB-1:0][`HFPC_CODE_W-1:0] pwm_discharge_current_code,
  input wire logic [`HFPC_CODE_W-1:0] initial_predischarge_code,
  input wire logic [`HFPC_NUM_HB-1:0][CW-1:0] ccp_fw_cycles,
  input wire logic [`HFPC_NUM_HB-1:0][CW-1:0] ccp_act_cycles,
  input wire logic [`HFPC_NUM_HB-1:0][CW-1:0] blank_cycles,
  input wire logic [`HFPC_NUM_HB-1:0] sh_high,
  input wire logic [`HFPC_NUM_HB-1:0] sh_low,
  input wire logic normal_mode,
  input wire logic charge_pump_enable,
  input wire logic vcc_undervoltage,
  input wire logic vs_overvoltage,
  input wire logic vsint_overvoltage,
  input wire logic cp_undervoltage,
  input wire logic charge_pump_overtemp_flag,
  input wire logic [`HFPC_NUM_HB-1:0] vds_overvoltage_event,
  input wire logic [`HFPC_NUM_HB-1:0] vds_overvoltage_clear,
  output logic [`HFPC_NUM_HB-1:0] gate_hs_on,
  output logic [`HFPC_NUM_HB-1:0] gate_ls_on,
  output logic [`HFPC_NUM_HB-1:0] passive_discharge_en,
  output logic [`HFPC_NUM_HB-1:0] afw_active,
  output logic [`HFPC_NUM_HB-1:0] generator_detected,
  output logic cp_uv_blank_active,
  output logic [`HFPC_NUM_HB-1:0][`HFPC_CUR_W-1:0] discharge_current,
  output logic [`HFPC_CUR_W-1:0] predischarge_current,
  output logic [`HFPC_STAT_W-1:0] switch_time_status_hb1,
  output logic [`HFPC_STAT_W-1:0] switch_time_status_hb2,
  output logic [`HFPC_STAT_W-1:0] switch_time_status_hb3,
  output logic [`HFPC_STAT_W-1:0] switch_time_status_hb4
);

  localparam int NHB = `HFPC_NUM_HB;
  localparam int TF = `HFPC_TF_W;
  localparam int BW = $clog2(CP_BLANK_CYC + 1);
  localparam logic [CW:0] ONE_X = {{CW{1'b0}}, 1'b1};
  localparam logic [CW:0] TF_MAX = (CW + 1)'({TF{1'b1}});

  function automatic logic [CW:0] sat_inc(input logic [CW:0] v);
    sat_inc = (&v) ? v : v + ONE_X;
  endfunction

  function automatic logic [TF-1:0] clip_tf(input logic [CW:0] v);
    clip_tf = (v > TF_MAX) ? TF_MAX[TF-1:0] : v[TF-1:0];
  endfunction

  logic [`HFPC_STAT_W-1:0] stat_w [NHB];
  logic [BW-1:0] blank_cnt_q;
  logic cp_en_q;
  logic global_dchg;

  //////////////////////////////////////////////////////////////////////////////
  // Pump undervoltage blank window, restarted by pump enable or undervoltage

  always_ff @(posedge clk_sys) begin
    if (srst) begin
      cp_en_q <= 1'b0;
      blank_cnt_q <= '0;
    end else if (ce) begin
      cp_en_q <= charge_pump_enable;
      if ((charge_pump_enable && !cp_en_q) || cp_undervoltage) begin
        blank_cnt_q <= BW'(CP_BLANK_CYC);
      end else if (blank_cnt_q != '0) begin
        blank_cnt_q <= blank_cnt_q - 1'b1;
      end
    end
  end

  assign cp_uv_blank_active = (blank_cnt_q != '0);

  assign global_dchg = vcc_undervoltage
    | vs_overvoltage | vsint_overvoltage
    | cp_undervoltage | cp_uv_blank_active | charge_pump_overtemp_flag;

  hfpc_cur_decode u_predchg (
    .clk_sys(clk_sys),
    .srst(srst),
    .ce(ce),
    .code(initial_predischarge_code),
    .current(predischarge_current)
  );

  assign switch_time_status_hb1 = stat_w[0];
  assign switch_time_status_hb2 = stat_w[1];
  assign switch_time_status_hb3 = stat_w[2];
  assign switch_time_status_hb4 = stat_w[3];

  //////////////////////////////////////////////////////////////////////////////
  // One half-bridge per pass

  for (genvar i = 0; i < NHB; i++) begin : g_hb
    logic pwm_q;
    logic pwm_rise;
    logic pwm_fall;
    logic [CW:0] run_q;
    logic [CW:0] ton_q;
    logic [CW:0] fw_x;
    logic [CW:0] act_x;
    logic [CW:0] sum_x;
    logic is_hs;
    logic mode_on;
    logic near_pwm;
    logic gen_d;
    logic high_w;
    logic low_w;
    logic load_ok;
    logic gen_ok;
    logic afw_d;
    logic afw_q;
    logic gen_q;
    logic ext_q;
    hfpc_seq_type seq_q;
    logic [CW-1:0] seq_cnt_q;
    logic act_in;
    logic del_pwm;
    logic pwm_cmd;
    logic opp_cmd;
    logic hs_q;
    logic ls_q;
    logic vds_q;
    logic dchg_w;
    logic dchg_q;
    hfpc_meas_type ms_q;
    logic meas_hs;
    logic meas_on;
    logic meas_on_q;
    logic near_m;
    logic far_m;
    logic [CW:0] mcnt_q;
    logic [CW:0] mtmo_q;
    logic [TF-1:0] tdon_q;
    logic [TF-1:0] tdoff_q;
    logic [TF-1:0] trise_q;
    logic [TF-1:0] tfall_q;

    assign is_hs = (halfbridge_mode_select[i] == `HFPC_MODE_HS);
    assign mode_on = is_hs || (halfbridge_mode_select[i] == `HFPC_MODE_LS);
    assign pwm_rise = pwm_in[i] && !pwm_q;
    assign pwm_fall = !pwm_in[i] && pwm_q;
    assign fw_x = {1'b0, ccp_fw_cycles[i]};
    assign act_x = {1'b0, ccp_act_cycles[i]};
    assign sum_x = fw_x + act_x;

    // Judged at the rising edge: run_q holds the off-time just ended
    assign high_w = (run_q < act_x);
    assign low_w = (ton_q < fw_x);
    assign load_ok = (ton_q > fw_x) && (run_q > sum_x);
    assign gen_ok = (run_q > fw_x) && (ton_q > sum_x);
    assign near_pwm = is_hs ? sh_high[i] : sh_low[i];
    assign gen_d = generator_detect_enable && near_pwm;
    assign afw_d = active_freewheel_enable[i] && mode_on && !high_w && !low_w
      && (gen_d ? gen_ok : load_ok);

    always_ff @(posedge clk_sys) begin
      if (srst) begin
        pwm_q <= 1'b0;
        run_q <= '0;
        ton_q <= '0;
      end else if (ce) begin
        pwm_q <= pwm_in[i];
        run_q <= (pwm_rise || pwm_fall) ? ONE_X : sat_inc(run_q);
        if (pwm_fall) begin
          ton_q <= run_q;
        end
      end
    end

    // Scheme is chosen once per period so a gate never glitches mid-cycle
    always_ff @(posedge clk_sys) begin
      if (srst) begin
        afw_q <= 1'b0;
        gen_q <= 1'b0;
        ext_q <= 1'b0;
      end else if (ce && pwm_rise) begin
        afw_q <= afw_d;
        gen_q <= gen_d && afw_d;
        ext_q <= high_w || low_w;
      end
    end

    // Active freewheel sequencer with both dead times
    assign act_in = gen_q ? !pwm_q : pwm_q;

    always_ff @(posedge clk_sys) begin
      if (srst) begin
        seq_q <= SEQ_DT_OFF;
        seq_cnt_q <= '0;
      end else if (ce) begin
        if (!afw_q || dchg_q) begin
          seq_q <= SEQ_DT_OFF;
          seq_cnt_q <= ccp_act_cycles[i];
        end else begin
          case (seq_q)
            SEQ_FW: begin
              if (act_in) begin
                seq_q <= SEQ_DT_ON;
                seq_cnt_q <= ccp_fw_cycles[i];
              end
            end
            SEQ_DT_ON: begin
              if (!act_in) begin
                seq_q <= SEQ_DT_OFF;
                seq_cnt_q <= ccp_act_cycles[i];
              end else if (seq_cnt_q <= CW'(1)) begin
                seq_q <= SEQ_ACT;
              end else begin
                seq_cnt_q <= seq_cnt_q - 1'b1;
              end
            end
            SEQ_ACT: begin
              if (!act_in) begin
                seq_q <= SEQ_DT_OFF;
                seq_cnt_q <= ccp_act_cycles[i];
              end
            end
            SEQ_DT_OFF: begin
              if (act_in) begin
                seq_q <= SEQ_DT_ON;
                seq_cnt_q <= ccp_fw_cycles[i];
              end else if (seq_cnt_q <= CW'(1)) begin
                seq_q <= SEQ_FW;
              end else begin
                seq_cnt_q <= seq_cnt_q - 1'b1;
              end
            end
            default: begin
              seq_q <= SEQ_DT_OFF;
              seq_cnt_q <= ccp_act_cycles[i];
            end
          endcase
        end
      end
    end

    hfpc_edge_delay #(
      .CW(CW)
    ) u_dly (
      .clk_sys(clk_sys),
      .srst(srst),
      .ce(ce),
      .din(pwm_q),
      .dly(ccp_fw_cycles[i]),
      .dout(del_pwm)
    );

    // Passive scheme: shifted PWM MOSFET only
    assign pwm_cmd = afw_q ? (gen_q ? (seq_q == SEQ_FW) : (seq_q == SEQ_ACT)) : del_pwm;
    assign opp_cmd = afw_q && (gen_q ? (seq_q == SEQ_ACT) : (seq_q == SEQ_FW));

    // Drain-source overvoltage hold, an event beats a clear
    always_ff @(posedge clk_sys) begin
      if (srst) begin
        vds_q <= 1'b0;
      end else if (ce) begin
        if (vds_overvoltage_event[i]) begin
          vds_q <= 1'b1;
        end else if (vds_overvoltage_clear[i]) begin
          vds_q <= 1'b0;
        end
      end
    end

    assign dchg_w = global_dchg || (normal_mode && ((halfbridge_mode_select[i] == `HFPC_MODE_OFF)
      || !charge_pump_enable || vds_q));

    always_ff @(posedge clk_sys) begin
      if (srst) begin
        dchg_q <= 1'b1;
        hs_q <= 1'b0;
        ls_q <= 1'b0;
      end else if (ce) begin
        dchg_q <= dchg_w;
        if (dchg_w || !mode_on) begin
          hs_q <= 1'b0;
          ls_q <= 1'b0;
        end else begin
          hs_q <= is_hs ? pwm_cmd : opp_cmd;
          ls_q <= is_hs ? opp_cmd : pwm_cmd;
        end
      end
    end

    // Switching time measurement on the selected MOSFET
    assign meas_hs = is_hs ^ (generator_detect_enable && gen_q);
    assign meas_on = meas_hs ? hs_q : ls_q;
    assign near_m = meas_hs ? sh_high[i] : sh_low[i];
    assign far_m = meas_hs ? sh_low[i] : sh_high[i];

    always_ff @(posedge clk_sys) begin
      if (srst) begin
        ms_q <= M_IDLE;
        meas_on_q <= 1'b0;
        mcnt_q <= '0;
        mtmo_q <= '0;
        tdon_q <= '0;
        tdoff_q <= '0;
        trise_q <= '0;
        tfall_q <= '0;
      end else if (ce) begin
        meas_on_q <= meas_on;
        mcnt_q <= sat_inc(mcnt_q);
        mtmo_q <= sat_inc(mtmo_q);
        if (ext_q) begin
          ms_q <= M_IDLE;
          tdon_q <= '0;
          tdoff_q <= '0;
          trise_q <= '0;
          tfall_q <= '0;
        end else begin
          case (ms_q)
            M_IDLE: begin
              mcnt_q <= '0;
              mtmo_q <= '0;
              if (meas_on && !meas_on_q) begin
                ms_q <= M_DON;
              end else if (!meas_on && meas_on_q) begin
                ms_q <= M_DOFF;
              end
            end
            M_DON: begin
              if (mtmo_q >= {1'b0, blank_cycles[i]}) begin
                tdon_q <= clip_tf(mcnt_q);
                trise_q <= '0;
                ms_q <= M_IDLE;
              end else if (!far_m) begin
                tdon_q <= clip_tf(mcnt_q);
                mcnt_q <= '0;
                ms_q <= M_RISE;
              end
            end
            M_RISE: begin
              if (near_m) begin
                trise_q <= clip_tf(mcnt_q);
                ms_q <= M_IDLE;
              end else if (mtmo_q >= {1'b0, blank_cycles[i]}) begin
                trise_q <= '0;
                ms_q <= M_IDLE;
              end
            end
            M_DOFF: begin
              if (mtmo_q >= act_x) begin
                tdoff_q <= clip_tf(mcnt_q);
                tfall_q <= '0;
                ms_q <= M_IDLE;
              end else if (!near_m) begin
                tdoff_q <= clip_tf(mcnt_q);
                mcnt_q <= '0;
                ms_q <= M_FALL;
              end
            end
            M_FALL: begin
              if (far_m) begin
                tfall_q <= clip_tf(mcnt_q);
                ms_q <= M_IDLE;
              end else if (mtmo_q >= act_x) begin
                tfall_q <= '0;
                ms_q <= M_IDLE;
              end
            end
            default: begin
              ms_q <= M_IDLE;
            end
          endcase
        end
      end
    end

    hfpc_cur_decode u_dchg (
      .clk_sys(clk_sys),
      .srst(srst),
      .ce(ce),
      .code(pwm_discharge_current_code[i]),
      .current(discharge_current[i])
    );

    assign stat_w[i][`HFPC_TDON_LSB +: TF] = tdon_q;
    assign stat_w[i][`HFPC_TDOFF_LSB +: TF] = tdoff_q;
    assign stat_w[i][`HFPC_TRISE_LSB +: TF] = trise_q;
    assign stat_w[i][`HFPC_TFALL_LSB +: TF] = tfall_q;
    assign gate_hs_on[i] = hs_q;
    assign gate_ls_on[i] = ls_q;
    assign passive_discharge_en[i] = dchg_q;
    assign afw_active[i] = afw_q;
    assign generator_detected[i] = gen_q;
  end

endmodule

// [sim/hfpc_bridge_model.sv]
// Phase node model of four external half-bridges carrying motor load current
`timescale 1ns/1ps
module hfpc_bridge_model
  import hfpc_pkg::*;
(
  input wire logic clk_sys,
  input wire logic [3:0] gate_hs_on,
  input wire logic [3:0] slow,
  output logic [3:0] sh_high,
  output logic [3:0] sh_low
);
  logic [3:0][31:0] hist_q = '0;

  // Phase follows the high-side gate; when it is off, load current freewheels to ground
  always_ff @(posedge clk_sys) begin
    for (int i = 0; i < 4; i++) hist_q[i] <= {hist_q[i][30:0], gate_hs_on[i]};
  end

  // Each half of the swing lasts d cycles; both comparators are low at mid rail
  always_comb begin
    int d;
    d = 2;
    for (int i = 0; i < 4; i++) begin
      d = slow[i] ? 15 : 2;
      sh_high[i] = hist_q[i][d-1] & hist_q[i][2*d-1];
      sh_low[i] = !(hist_q[i][d-1] | hist_q[i][2*d-1]);
    end
  end
endmodule

// [sim/hfpc_top_properties.sv]
// Port checks of the half-bridge PWM freewheel controller
`timescale 1ns/1ps
module hfpc_top_props
  import hfpc_pkg::*;
#(
  parameter int CW = 10
) (
  input wire logic clk_sys,
  input wire logic srst,
  input wire logic ce,
  input wire logic [3:0] pwm_in,
  input wire logic [3:0][1:0] halfbridge_mode_select,
  input wire logic [5:0] initial_predischarge_code,
  input wire logic [3:0][CW-1:0] ccp_fw_cycles,
  input wire logic normal_mode,
  input wire logic charge_pump_enable,
  input wire logic vcc_undervoltage,
  input wire logic vs_overvoltage,
  input wire logic vsint_overvoltage,
  input wire logic cp_undervoltage,
  input wire logic charge_pump_overtemp_flag,
  input wire logic [3:0] gate_hs_on,
  input wire logic [3:0] gate_ls_on,
  input wire logic [3:0] passive_discharge_en,
  input wire logic [3:0] afw_active,
  input wire logic cp_uv_blank_active,
  input wire logic [10:0] predischarge_current
);
  // Frozen state under a low clock enable is not judged
  default clocking cb @(posedge clk_sys);
  endclocking
  default disable iff (srst || !ce);
  ////////////////////////////////////////////////////////////
  property p_vcc_uv;
    vcc_undervoltage |=> passive_discharge_en == 4'hF;
  endproperty
  a_vcc_uv: assert property (p_vcc_uv) else $error("vcc undervoltage without discharge");
  property p_ov;
    vs_overvoltage || vsint_overvoltage |=> passive_discharge_en == 4'hF;
  endproperty
  a_ov: assert property (p_ov) else $error("overvoltage without discharge");
  property p_pump;
    cp_undervoltage || charge_pump_overtemp_flag || cp_uv_blank_active |=> passive_discharge_en == 4'hF;
  endproperty
  a_pump: assert property (p_pump) else $error("pump fault without discharge");
  property p_charge_pump_enable;
    normal_mode && !charge_pump_enable |=> passive_discharge_en == 4'hF;
  endproperty
  a_charge_pump_enable: assert property (p_charge_pump_enable) else $error("pump off without discharge");
  property p_mode_off;
    normal_mode && halfbridge_mode_select[3] == 2'h0 |=> passive_discharge_en[3];
  endproperty
  a_mode_off: assert property (p_mode_off) else $error("mode off without discharge");
  property p_release;
    !normal_mode && !(vcc_undervoltage || vs_overvoltage || vsint_overvoltage || cp_undervoltage
      || charge_pump_overtemp_flag || cp_uv_blank_active) |=> passive_discharge_en == 4'h0;
  endproperty
  a_release: assert property (p_release) else $error("discharge held without cause");
  property p_gates_off;
    passive_discharge_en[0] [*2] |-> !gate_hs_on[0] && !gate_ls_on[0];
  endproperty
  a_gates_off: assert property (p_gates_off) else $error("gate on during discharge");
  property p_lag;
    $rose(pwm_in[0]) && ccp_fw_cycles[0] == 10'h003 && halfbridge_mode_select[0] == 2'h1
      && !afw_active[0] && !passive_discharge_en[0] |-> ##6 $rose(gate_hs_on[0]);
  endproperty
  a_lag: assert property (p_lag) else $error("PWM gate lag wrong");
  property p_opp_off;
    (!afw_active[0] && halfbridge_mode_select[0] == 2'h1) [*3] |-> !gate_ls_on[0];
  endproperty
  a_opp_off: assert property (p_opp_off) else $error("opposite gate on without freewheel");
  property p_cur_max;
    initial_predischarge_code == 6'h3F |=> predischarge_current == 11'h7D0;
  endproperty
  a_cur_max: assert property (p_cur_max) else $error("top code current wrong");
  c_lag: cover property ($rose(gate_hs_on[0]));
  c_afw: cover property ($rose(afw_active[1]));
  c_rel: cover property ($fell(passive_discharge_en[0]));
endmodule

bind hfpc_top hfpc_top_props #(.CW(CW)) u_props (.clk_sys, .srst, .ce, .pwm_in, .halfbridge_mode_select,
  .initial_predischarge_code, .ccp_fw_cycles, .normal_mode, .charge_pump_enable, .vcc_undervoltage,
  .vs_overvoltage, .vsint_overvoltage, .cp_undervoltage, .charge_pump_overtemp_flag, .gate_hs_on, .gate_ls_on,
  .passive_discharge_en, .afw_active, .cp_uv_blank_active, .predischarge_current);

// [sim/hfpc_top_test.sv]
// Self-checking bench of the half-bridge PWM freewheel controller
`timescale 1ns/1ps
module hfpc_top_test
  import hfpc_pkg::*;
;
  logic clk_sys = 0;
  logic srst = 1;
  logic ce = 1;
  logic generator_detect_enable = 0;
  logic normal_mode = 0;
  logic charge_pump_enable = 0;
  logic [3:0] pwm_in = 0, active_freewheel_enable = 4'h2, slow = 0;
  logic [3:0] vds_overvoltage_event = 0, vds_overvoltage_clear = 0;
  logic [4:0] flt = 0;
  logic [5:0] initial_predischarge_code = 0;
  logic [3:0][1:0] halfbridge_mode_select = 8'hE5;
  logic [3:0][5:0] pwm_discharge_current_code = 0;
  logic [3:0][9:0] ccp_fw_cycles = {4{10'h003}}, ccp_act_cycles = {4{10'h008}}, blank_cycles = {4{10'h014}};
  wire logic vcc_undervoltage = flt[0];
  wire logic vs_overvoltage = flt[1];
  wire logic vsint_overvoltage = flt[2];
  wire logic cp_undervoltage = flt[3];
  wire logic charge_pump_overtemp_flag = flt[4];
  logic [3:0] sh_high, sh_low, gate_hs_on, gate_ls_on, passive_discharge_en, afw_active, generator_detected;
  logic cp_uv_blank_active, lsbad, afw;
  logic [3:0][10:0] discharge_current;
  logic [10:0] predischarge_current, prev;
  logic [31:0] switch_time_status_hb1, switch_time_status_hb2, switch_time_status_hb3, switch_time_status_hb4;
  int failures = 0, n_checks = 0, dly;

  // Short blank count keeps the pump scenarios brief
  hfpc_top #(.CP_BLANK_CYC(8)) dut (.clk_sys, .srst, .ce, .pwm_in, .active_freewheel_enable,
    .generator_detect_enable, .halfbridge_mode_select, .pwm_discharge_current_code, .initial_predischarge_code,
    .ccp_fw_cycles, .ccp_act_cycles, .blank_cycles, .sh_high, .sh_low, .normal_mode, .charge_pump_enable,
    .vcc_undervoltage, .vs_overvoltage, .vsint_overvoltage, .cp_undervoltage, .charge_pump_overtemp_flag,
    .vds_overvoltage_event, .vds_overvoltage_clear, .gate_hs_on, .gate_ls_on, .passive_discharge_en, .afw_active,
    .generator_detected, .cp_uv_blank_active, .discharge_current, .predischarge_current,
    .switch_time_status_hb1, .switch_time_status_hb2, .switch_time_status_hb3, .switch_time_status_hb4);
  hfpc_bridge_model pm (.clk_sys, .gate_hs_on, .slow, .sh_high, .sh_low);

  initial forever #2 clk_sys = ~clk_sys;
  ////////////////////////////////////////////////////////////
  task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
    n_checks++;
    if (got !== exp) begin
      failures++;
      $display("ERROR %s expected %h seen %h", what, exp, got);
    end
  endtask
  task automatic tick(input int n);
    repeat (n) @(negedge clk_sys);
  endtask
  task automatic conclude();
    $display("Checks %0d failures %0d", n_checks, failures);
    if (failures == 0 && n_checks > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask
  // Bridge idx and bridge 1 (freewheel enabled) switch together; results describe the last period, except lsbad, which covers every period
  task automatic run(input int idx, input int on, input int off, input int n);
    logic sel, prv;
    sel = halfbridge_mode_select[idx][1];
    prv = 1;
    dly = 0;
    lsbad = 0;
    repeat (n) for (int k = 0; k < on + off; k++) begin
      pwm_in = (k < on) ? (4'h2 | (4'h1 << idx)) : 4'h0;
      tick(1);
      if ((sel ? gate_ls_on[idx] : gate_hs_on[idx]) && !prv) dly = k + 1;
      prv = sel ? gate_ls_on[idx] : gate_hs_on[idx];
      lsbad |= sel ? gate_hs_on[idx] : gate_ls_on[idx];
      if (k == 3) afw = 0;
      afw |= afw_active[1];
    end
  endtask
  ////////////////////////////////////////////////////////////
  initial begin
    tick(20);
    srst = 0;
    for (int c = 0; c < 64; c++) begin
      prev = predischarge_current;
      initial_predischarge_code = 6'(c);
      pwm_discharge_current_code[3] = 6'(c);
      tick(2);
      if (c == 0) chk("cur_min", 32'h00A, predischarge_current);
      else chk("cur_rise", 32'h1, predischarge_current > prev);
    end
    chk("cur_max", 32'h7D0, predischarge_current);
    chk("cur_max_hb4", 32'h7D0, discharge_current[3]);
    // Low clock enable must freeze the decoder output
    ce = 0;
    initial_predischarge_code = 6'h00;
    tick(2);
    chk("ce_hold", 32'h7D0, predischarge_current);
    ce = 1;
    tick(2);
    chk("ce_run", 32'h00A, predischarge_current);
    normal_mode = 1;
    charge_pump_enable = 1;
    tick(2);
    chk("blank", 32'h1, cp_uv_blank_active);
    chk("dchg_blank", 32'hF, passive_discharge_en);
    tick(12);
    chk("dchg_rel", 32'h0, passive_discharge_en);
    for (int i = 0; i < 5; i++) begin
      flt = 5'h01 << i;
      tick(3);
      chk("dchg_flag", 32'hF, passive_discharge_en);
      flt = 5'h00;
      tick(12);
      chk("dchg_flag_rel", 32'h0, passive_discharge_en);
    end
    charge_pump_enable = 0;
    tick(3);
    chk("dchg_charge_pump_enable", 32'hF, passive_discharge_en);
    normal_mode = 0;
    tick(3);
    chk("dchg_other_mode", 32'h0, passive_discharge_en);
    charge_pump_enable = 1;
    tick(12);
    normal_mode = 1;
    halfbridge_mode_select[3] = 2'h0;
    tick(3);
    chk("dchg_mode", 32'h8, passive_discharge_en);
    halfbridge_mode_select[3] = 2'h3;
    vds_overvoltage_event = 4'h2;
    tick(1);
    vds_overvoltage_event = 4'h0;
    tick(5);
    chk("dchg_vds", 32'h2, passive_discharge_en);
    vds_overvoltage_clear = 4'h2;
    tick(1);
    vds_overvoltage_clear = 4'h0;
    tick(3);
    chk("dchg_vds_rel", 32'h0, passive_discharge_en);
    generator_detect_enable = 1;
    run(0, 30, 30, 3);
    chk("lag_norm", 32'h6, dly);
    chk("afw_norm", 32'h1, afw);
    chk("tdon", 32'h1, |switch_time_status_hb1[7:0]);
    chk("trise", 32'h1, |switch_time_status_hb1[23:16]);
    chk("tfall", 32'h1, |switch_time_status_hb1[31:24]);
    chk("tdon_hb2", 32'h1, |switch_time_status_hb2[7:0]);
    chk("gen_load", 32'h0, generator_detected);
    chk("stat_hb4", 32'h0, switch_time_status_hb4);
    // Detection is unreliable at extreme duty cycles
    generator_detect_enable = 0;
    for (int j = 0; j < 4; j++) begin
      run(j[0] ? 2 : 0, j[1] ? 2 : 30, j[1] ? 30 : 2, 3);
      chk("lag_ext", 32'h6, dly);
      chk("opp_off", 32'h0, lsbad);
      chk("afw_ext", 32'h0, afw);
      chk("stat_ext", 32'h0, switch_time_status_hb1);
      chk("stat_ext3", 32'h0, switch_time_status_hb3);
    end
    slow = 4'h1;
    run(0, 30, 30, 3);
    chk("trise_slow", 32'h0, switch_time_status_hb1[23:16]);
    chk("tfall_slow", 32'h0, switch_time_status_hb1[31:24]);
    conclude();
  end

  // Whole sequence needs about 1000 cycles
  initial begin
    #20000;
    failures++;
    $display("ERROR watchdog expected done seen hang");
    conclude();
  end
endmodule
